// ==== rtl/input_clock_config.sv ====
// register file and edge logic for the four reference clock inputs
`timescale 1ns/1ps
`default_nettype none
module input_clock_config
    import icc_pkg::*;
#(
    parameter int MISS_LIMIT = MISS_CYC
) (
    input  wire logic              SYS_CLK_I,
    input  wire logic              SRST_I,
    input  wire logic              CE_I,
    input  wire logic [ADDR_W-1:0] ADDR_I,
    input  wire logic              WR_I,
    input  wire logic              RD_I,
    input  wire logic [DATA_W-1:0] WDATA_I,
    output logic      [DATA_W-1:0] RDATA_O,
    output logic                   RVALID_O,
    input  wire logic [NUM_IN-1:0] CLK_IN_I,
    output logic      [NUM_IN-1:0] REF_EDGE_O,
    output logic      [NUM_IN-1:0] VALID_O,
    output logic      [NUM_IN-1:0] EDGE_SEL_O,
    output logic      [DATA_W-1:0] OSC_AMP_O,
    output logic      [3:0]        XA_CAP_O,
    output logic      [3:0]        XB_CAP_O
);
    // index 0 is the crystal input, 1..3 the clock inputs
    logic [DATA_W-1:0] cfg_reg [NUM_IN];
    logic [DATA_W-1:0] amp_reg;
    logic [DATA_W-1:0] cap_reg;

    logic [NUM_IN-1:0] sync_a;
    logic [NUM_IN-1:0] sync_b;
    logic [NUM_IN-1:0] prev;
    logic [NUM_IN-1:0] rise;
    logic [NUM_IN-1:0] fall;
    logic [NUM_IN-1:0] sel_edge;
    logic [NUM_IN-1:0] tick;
    logic [NUM_IN-1:0] valid;

    logic [DATA_W-1:0] next_rdata;
    logic              hit_cfg;
    logic [1:0]        cfg_idx;

    chan_cfg_if cfg_bus [NUM_IN] ();

    // address decode shared by the write and read paths
    always_comb begin
        hit_cfg = 1'b1;
        cfg_idx = 2'h0;
        case (ADDR_I)
            ADDR_XA_CFG: cfg_idx = 2'h0;
            ADDR_IC1:    cfg_idx = 2'h1;
            ADDR_IC2:    cfg_idx = 2'h2;
            ADDR_IC3:    cfg_idx = 2'h3;
            default:     hit_cfg = 1'b0;
        endcase
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            for (int i = 0; i < NUM_IN; i++) begin
                cfg_reg[i] <= RESET_VAL;
            end
        end else if (CE_I && WR_I && hit_cfg) begin
            // bit 7 is reserved and never stored
            cfg_reg[cfg_idx] <= WDATA_I & CFG_MASK;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            amp_reg <= RESET_VAL;
            cap_reg <= RESET_VAL;
        end else if (CE_I && WR_I) begin
            if (ADDR_I == ADDR_XA_AMP) begin
                amp_reg <= WDATA_I;
            end
            if (ADDR_I == ADDR_XA_CAP) begin
                cap_reg <= WDATA_I;
            end
        end
    end

    always_comb begin
        next_rdata = '0;
        if (hit_cfg) begin
            next_rdata = cfg_reg[cfg_idx];
        end else if (ADDR_I == ADDR_XA_AMP) begin
            next_rdata = amp_reg;
        end else if (ADDR_I == ADDR_XA_CAP) begin
            next_rdata = cap_reg;
        end
    end

    // unmapped addresses read as zero; no error is signalled
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            RDATA_O  <= '0;
            RVALID_O <= 1'b0;
        end else if (CE_I) begin
            RVALID_O <= RD_I;
            if (RD_I) begin
                RDATA_O <= next_rdata;
            end
        end
    end

    // analog trims are held in flops so the pins never glitch on a read
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            OSC_AMP_O <= '0;
            XA_CAP_O  <= '0;
            XB_CAP_O  <= '0;
        end else if (CE_I) begin
            OSC_AMP_O <= amp_reg;
            XB_CAP_O  <= cap_reg[XB_CAP_LSB +: 4];
            XA_CAP_O  <= cap_reg[XA_CAP_LSB +: 4];
        end
    end

    // pins come from foreign clocks; the edge view is only as fine as SYS_CLK_I
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            sync_a <= '0;
            sync_b <= '0;
            prev   <= '0;
        end else if (CE_I) begin
            sync_a <= CLK_IN_I;
            sync_b <= sync_a;
            prev   <= sync_b;
        end
    end

    assign rise = sync_b & ~prev;
    assign fall = ~sync_b & prev;

    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            EDGE_SEL_O <= '0;
            REF_EDGE_O <= '0;
            VALID_O    <= '0;
        end else if (CE_I) begin
            REF_EDGE_O <= tick;
            VALID_O    <= valid;
            for (int i = 0; i < NUM_IN; i++) begin
                EDGE_SEL_O[i] <= cfg_reg[i][EDGE_BIT];
            end
        end
    end

    for (genvar g = 0; g < NUM_IN; g++) begin : g_chan
        assign cfg_bus[g].edge_select          = cfg_reg[g][EDGE_BIT];
        assign cfg_bus[g].monitor_feed_disable = cfg_reg[g][FEED_BIT];
        assign cfg_bus[g].valid_window_sel     = cfg_reg[g][WIN_LSB +: 3];
        assign cfg_bus[g].input_prediv         = cfg_reg[g][DIV_LSB +: 2];

        // the pll path follows the chosen edge, the monitor always rising
        assign sel_edge[g] = cfg_bus[g].edge_select ? fall[g] : rise[g];

        chan_divider #(
            .IS_XTAL (g == XTAL_CH)
        ) u_div (
            .clk_i  (SYS_CLK_I),
            .srst_i (SRST_I),
            .ce_i   (CE_I),
            .edge_i (sel_edge[g]),
            .cfg    (cfg_bus[g]),
            .tick_o (tick[g])
        );

        chan_monitor #(
            .MISS_LIMIT (MISS_LIMIT)
        ) u_mon (
            .clk_i   (SYS_CLK_I),
            .srst_i  (SRST_I),
            .ce_i    (CE_I),
            .rise_i  (rise[g]),
            .cfg     (cfg_bus[g]),
            .valid_o (valid[g])
        );

        a_edge_polarity: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
            sel_edge[g] |-> (cfg_reg[g][EDGE_BIT] ? !sync_b[g] : sync_b[g]))
            else $error("selected edge has the wrong polarity");

        a_feed_clears: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
            CE_I && cfg_reg[g][FEED_BIT] ##1 CE_I |=> !VALID_O[g])
            else $error("valid while monitor feed is off");

        a_tick_from_edge: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
            $past(CE_I) && tick[g] |-> $past(sel_edge[g]))
            else $error("divider tick without a selected edge");
    end

    a_cfg_write: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
        CE_I && WR_I && ADDR_I == ADDR_IC2 |=> cfg_reg[2] == ($past(WDATA_I) & CFG_MASK))
        else $error("clock input 2 register not written");
    a_cfg_isolated: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
        CE_I && WR_I && ADDR_I == ADDR_IC3 |=> cfg_reg[1] == $past(cfg_reg[1]))
        else $error("write leaked into another input register");
    a_xb_cap_path: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
        CE_I && WR_I && ADDR_I == ADDR_XA_CAP ##1 CE_I |=> XB_CAP_O == $past(WDATA_I, 2) >> 4)
        else $error("xb trim did not follow upper nibble");
    a_xa_cap_path: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
        CE_I && WR_I && ADDR_I == ADDR_XA_CAP ##1 CE_I |=> XA_CAP_O == ($past(WDATA_I, 2) & 8'h0F))
        else $error("xa trim did not follow lower nibble");
    a_feed_to_pin: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
        CE_I && cfg_reg[XTAL_CH][FEED_BIT] ##1 CE_I && cfg_reg[XTAL_CH][FEED_BIT]
        |=> !VALID_O[XTAL_CH])
        else $error("crystal valid while its monitor feed is off");
    a_read_reserved: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
        CE_I && RD_I && hit_cfg |=> RVALID_O && !RDATA_O[7])
        else $error("reserved config bit read as one");
    a_freeze: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
        !CE_I |=> $stable(VALID_O) && $stable(REF_EDGE_O) && $stable(RDATA_O))
        else $error("state moved while clock enable low");

    // each write lands in its own register and nowhere else
    a_xa_cfg_write: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
        CE_I && WR_I && ADDR_I == ADDR_XA_CFG |=> cfg_reg[0] == ($past(WDATA_I) & CFG_MASK))
        else $error("crystal config register not written");

    a_ic1_write: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
        CE_I && WR_I && ADDR_I == ADDR_IC1 |=> cfg_reg[1] == ($past(WDATA_I) & CFG_MASK))
        else $error("clock input 1 register not written");

    a_ic3_write: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
        CE_I && WR_I && ADDR_I == ADDR_IC3 |=> cfg_reg[3] == ($past(WDATA_I) & CFG_MASK))
        else $error("clock input 3 register not written");

    a_amp_write: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
        CE_I && WR_I && ADDR_I == ADDR_XA_AMP |=> amp_reg == $past(WDATA_I))
        else $error("amplifier level not written");

    a_cap_write: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
        CE_I && WR_I && ADDR_I == ADDR_XA_CAP |=> cap_reg == $past(WDATA_I))
        else $error("load trim register not written");

    a_cfg_held: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
        !(CE_I && WR_I) |=> cfg_reg[1] == $past(cfg_reg[1]) && cfg_reg[2] == $past(cfg_reg[2])
            && cfg_reg[3] == $past(cfg_reg[3]))
        else $error("config register moved without a write");

    // reads answer one cycle later with the value from before a same-cycle write
    a_read_ic2: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
        CE_I && RD_I && ADDR_I == ADDR_IC2 |=> RVALID_O && RDATA_O == $past(cfg_reg[2]))
        else $error("clock input 2 register read back wrong");

    a_read_amp: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
        CE_I && RD_I && ADDR_I == ADDR_XA_AMP |=> RDATA_O == $past(amp_reg))
        else $error("amplifier level read back wrong");

    a_read_unmapped: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
        CE_I && RD_I && !hit_cfg && ADDR_I != ADDR_XA_AMP && ADDR_I != ADDR_XA_CAP
        |=> RDATA_O == 8'h00)
        else $error("unmapped address read as nonzero");

    a_rvalid_pulse: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
        CE_I && !RD_I |=> !RVALID_O)
        else $error("read valid without a read strobe");

    a_rdata_hold: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
        CE_I && !RD_I |=> $stable(RDATA_O))
        else $error("read data moved without a read strobe");

    // outputs are registered copies of the state one cycle earlier
    a_amp_path: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
        CE_I |=> OSC_AMP_O == $past(amp_reg))
        else $error("amplifier output does not follow its register");

    a_cap_hold: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
        CE_I && !(WR_I && ADDR_I == ADDR_XA_CAP) ##1 CE_I |=> $stable({XB_CAP_O, XA_CAP_O}))
        else $error("load trims moved without a write");

    a_edge_sel_copy: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
        CE_I |=> EDGE_SEL_O == $past({cfg_reg[3][EDGE_BIT], cfg_reg[2][EDGE_BIT],
                                      cfg_reg[1][EDGE_BIT], cfg_reg[0][EDGE_BIT]}))
        else $error("edge select output does not follow its bits");

    a_valid_copy: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
        CE_I |=> VALID_O == $past(valid))
        else $error("valid output does not follow the monitors");

    a_ref_copy: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
        CE_I |=> REF_EDGE_O == $past(tick))
        else $error("reference edge output does not follow the dividers");

    a_sync_chain: assert property (@(posedge SYS_CLK_I) disable iff (SRST_I)
        CE_I |=> sync_b == $past(sync_a) && prev == $past(sync_b))
        else $error("pin synchroniser skipped a stage");
endmodule
`default_nettype wire

// ==== rtl/icc_pkg.sv ====
// constants, register map and decode functions for the input clock configuration block
package icc_pkg;
    localparam int             NUM_IN      = 4;
    localparam int             XTAL_CH     = 0;
    localparam int             ADDR_W      = 10;
    localparam int             DATA_W      = 8;
    localparam int             RUN_W       = 11;
    localparam int             CLK_MHZ     = 100;
    localparam int             MISS_NS     = 320;
    localparam int             MISS_CYC    = (MISS_NS * CLK_MHZ) / 1000;
    localparam logic [9:0]     ADDR_XA_CFG = 10'h300;
    localparam logic [9:0]     ADDR_XA_AMP = 10'h301;
    localparam logic [9:0]     ADDR_XA_CAP = 10'h302;
    localparam logic [9:0]     ADDR_IC1    = 10'h303;
    localparam logic [9:0]     ADDR_IC2    = 10'h304;
    localparam logic [9:0]     ADDR_IC3    = 10'h305;
    localparam int             EDGE_BIT    = 6;
    localparam int             FEED_BIT    = 5;
    localparam int             WIN_LSB     = 2;
    localparam int             DIV_LSB     = 0;
    localparam int             XB_CAP_LSB  = 4;
    localparam int             XA_CAP_LSB  = 0;
    localparam logic [7:0]     CFG_MASK    = 8'h7F;
    localparam logic [7:0]     RESET_VAL   = 8'h00;

    // validation run length in input cycles; zero marks an unused code
    function automatic logic [RUN_W-1:0] win_len(input logic [2:0] sel);
        case (sel)
            3'h0:    win_len = 11'h001;
            3'h1:    win_len = 11'h004;
            3'h2:    win_len = 11'h010;
            3'h3:    win_len = 11'h040;
            3'h4:    win_len = 11'h100;
            3'h5:    win_len = 11'h400;
            default: win_len = 11'h000;
        endcase
    endfunction

    // crystal input only knows divide by 1 and 2; its unused codes fall back to 1
    function automatic logic [3:0] div_ratio(input logic [1:0] code, input logic xtal);
        case (code)
            2'h0:    div_ratio = 4'h1;
            2'h1:    div_ratio = 4'h2;
            2'h2:    div_ratio = xtal ? 4'h1 : 4'h4;
            default: div_ratio = xtal ? 4'h1 : 4'h8;
        endcase
    endfunction
endpackage

// ==== rtl/chan_cfg_if.sv ====
// per-input configuration carried from the register file to the channel logic
`timescale 1ns/1ps
`default_nettype none
interface chan_cfg_if;
    logic       edge_select;
    logic       monitor_feed_disable;
    logic [2:0] valid_window_sel;
    logic [1:0] input_prediv;
    modport ctrl (output edge_select, monitor_feed_disable, valid_window_sel, input_prediv);
    modport user (input edge_select, monitor_feed_disable, valid_window_sel, input_prediv);
endinterface
`default_nettype wire

// ==== rtl/chan_monitor.sv ====
// activity monitor: declares an input valid after an unbroken run of edges
`timescale 1ns/1ps
`default_nettype none
module chan_monitor
    import icc_pkg::*;
#(
    parameter int GAP_W      = 8,
    parameter int MISS_LIMIT = MISS_CYC
) (
    input  wire logic   clk_i,
    input  wire logic   srst_i,
    input  wire logic   ce_i,
    input  wire logic   rise_i,
    chan_cfg_if.user    cfg,
    output var  logic   valid_o
);
    localparam logic [GAP_W-1:0] GAP_TOP = GAP_W'(MISS_LIMIT - 1);

    logic [GAP_W-1:0] gap;
    logic [RUN_W-1:0] run;
    logic [RUN_W-1:0] next_run;
    logic [RUN_W-1:0] len;
    logic             missing;

    assign len     = win_len(cfg.valid_window_sel);
    // an input that stays quiet for the whole gap budget has lost an edge
    assign missing = (gap == GAP_TOP) && !rise_i;

    always_comb begin
        next_run = run;
        if (cfg.monitor_feed_disable || missing) begin
            next_run = '0;
        end else if (rise_i && (run < len)) begin
            next_run = run + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            gap <= '0;
        end else if (ce_i) begin
            if (rise_i || cfg.monitor_feed_disable) begin
                gap <= '0;
            end else if (gap != GAP_TOP) begin
                gap <= gap + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            run     <= '0;
            valid_o <= 1'b0;
        end else if (ce_i) begin
            run     <= next_run;
            valid_o <= (len != '0) && (next_run >= len);
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);

    // the flag was formed against last cycle's window, so it is held to that one
    a_valid_needs_run: assert property ($past(ce_i) && valid_o
        |-> (run >= $past(len)) && ($past(len) != '0))
        else $error("valid without a full run");
    a_missing_restart: assert property (ce_i && missing |=> (run == '0) && !valid_o)
        else $error("missing edge did not restart the run");
    a_feed_blocks: assert property (ce_i && cfg.monitor_feed_disable |=> !valid_o)
        else $error("valid while monitor feed disabled");
    a_window_64: assert property (cfg.valid_window_sel == 3'h3 |-> len == 11'h040)
        else $error("window code 3 is not 64 cycles");
endmodule
`default_nettype wire

// ==== rtl/chan_divider.sv ====
// high-speed pre-divider: one tick for every ratio selected edges
`timescale 1ns/1ps
`default_nettype none
module chan_divider
    import icc_pkg::*;
#(
    parameter bit IS_XTAL = 1'b0
) (
    input  wire logic   clk_i,
    input  wire logic   srst_i,
    input  wire logic   ce_i,
    input  wire logic   edge_i,
    chan_cfg_if.user    cfg,
    output var  logic   tick_o
);
    logic [3:0] ratio;
    logic [3:0] cnt;

    assign ratio = div_ratio(cfg.input_prediv, IS_XTAL);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cnt    <= '0;
            tick_o <= 1'b0;
        end else if (ce_i) begin
            tick_o <= 1'b0;
            if (edge_i) begin
                // a ratio lowered mid-count wraps at once instead of running past it
                if (cnt >= ratio - 1'b1) begin
                    cnt    <= '0;
                    tick_o <= 1'b1;
                end else begin
                    cnt <= cnt + 1'b1;
                end
            end
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);

    a_tick_on_wrap: assert property (ce_i && edge_i && cnt == ratio - 1'b1 |=> tick_o)
        else $error("divider missed its wrap tick");
    a_no_idle_tick: assert property (ce_i && !edge_i |=> !tick_o)
        else $error("tick without a selected edge");
    a_xtal_ratio: assert property (IS_XTAL |-> ratio <= 4'h2)
        else $error("crystal divider beyond 2");
    a_div8: assert property (!IS_XTAL && cfg.input_prediv == 2'h3 |-> ratio == 4'h8)
        else $error("code 3 is not divide by 8");
endmodule
`default_nettype wire

// ==== tb/clk_source_model.sv ====
// reference clock source standing in for a crystal or an external oscillator
`timescale 1ns/1ps
`default_nettype none
module clk_source_model #(
    parameter int HALF_NS = 40
) (
    input  wire logic run_i,
    output var  logic clk_o
);
    // a stopped source holds its last level, as a dead oscillator would
    // the 3 ns start offset keeps its edges clear of the system clock edges
    initial begin
        clk_o = 1'b0;
        #3;
        forever begin
            #(HALF_NS);
            if (run_i) begin
                clk_o = ~clk_o;
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb/test_input_clock_config.sv ====
// self-checking bench for the input clock configuration block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin failures++; \
    $display("unexpected %s: expected %h, seen %h", nm, ex, got); end end
module test_input_clock_config;
    import icc_pkg::*;
    localparam int MISS = 16;
    localparam int PER  = 8;
    logic              SYS_CLK_I;
    logic              SRST_I;
    logic              CE_I;
    logic              WR_I;
    logic              RD_I;
    logic [ADDR_W-1:0] ADDR_I;
    logic [DATA_W-1:0] WDATA_I;
    logic [DATA_W-1:0] RDATA_O;
    logic              RVALID_O;
    logic [NUM_IN-1:0] REF_EDGE_O;
    logic [NUM_IN-1:0] VALID_O;
    logic [NUM_IN-1:0] EDGE_SEL_O;
    logic [DATA_W-1:0] OSC_AMP_O;
    logic [3:0]        XA_CAP_O;
    logic [3:0]        XB_CAP_O;
    logic [3:0]        src_run;
    wire  [3:0]        src_clk;
    int                failures = 0;
    int                checks = 0;
    int                o0;
    int                o1;

    for (genvar g = 0; g < 4; g++) begin : g_src
        clk_source_model clk_source_model_i (.run_i(src_run[g]), .clk_o(src_clk[g]));
    end

    input_clock_config #(.MISS_LIMIT(MISS)) input_clock_config_i (
        .SYS_CLK_I  (SYS_CLK_I),
        .SRST_I     (SRST_I),
        .CE_I       (CE_I),
        .ADDR_I     (ADDR_I),
        .WR_I       (WR_I),
        .RD_I       (RD_I),
        .WDATA_I    (WDATA_I),
        .RDATA_O    (RDATA_O),
        .RVALID_O   (RVALID_O),
        .CLK_IN_I   (src_clk),
        .REF_EDGE_O (REF_EDGE_O),
        .VALID_O    (VALID_O),
        .EDGE_SEL_O (EDGE_SEL_O),
        .OSC_AMP_O  (OSC_AMP_O),
        .XA_CAP_O   (XA_CAP_O),
        .XB_CAP_O   (XB_CAP_O)
    );

    initial begin
        SYS_CLK_I = 1'b0;
        forever #5 SYS_CLK_I = ~SYS_CLK_I;
    end

    task automatic step(input int n);
        repeat (n) begin
            @(posedge SYS_CLK_I);
            #1;
        end
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        ADDR_I = a;
        WDATA_I = d;
        WR_I = 1'b1;
        step(1);
        WR_I = 1'b0;
        step(1);
    endtask

    task automatic rd(input logic [9:0] a, input logic [7:0] ex);
        ADDR_I = a;
        RD_I = 1'b1;
        step(1);
        RD_I = 1'b0;
        `CHK("read valid", 1'b1, RVALID_O)
        `CHK("read data", ex, RDATA_O)
        step(1);
    endtask

    task automatic pulse_gap(input int ch, output int n);
        n = 0;
        do begin
            step(1);
            n++;
        end while (REF_EDGE_O[ch] !== 1'b1 && n < 400);
    endtask

    // the first two gaps after a ratio change may be short, so they are skipped
    task automatic div_chk(input int ch, input int ex);
        int n;
        pulse_gap(ch, n);
        pulse_gap(ch, n);
        pulse_gap(ch, n);
        `CHK("ref edge spacing", ex, n)
    endtask

    task automatic edge_ofs(output int n);
        repeat (2) begin
            @(posedge src_clk[1]);
            n = 0;
            do begin
                step(1);
                n++;
            end while (REF_EDGE_O[1] !== 1'b1 && n < 20);
        end
    endtask

    task automatic valid_time(input int ch, input int len);
        int n;
        n = 0;
        while (VALID_O[ch] !== 1'b1 && n < 9000) begin
            step(1);
            n++;
        end
        `CHK("valid delay", 1'b1, (n >= (len - 1) * PER) && (n <= len * PER + 12))
    endtask

    task automatic end_of_test;
        if (failures == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #400_000;
        failures++;
        end_of_test;
    end

    initial begin
        CE_I = 1'b1;
        WR_I = 1'b0;
        RD_I = 1'b0;
        ADDR_I = '0;
        WDATA_I = '0;
        SRST_I = 1'b1;
        src_run = 4'hF;
        repeat (8) @(posedge SYS_CLK_I);
        #1;
        SRST_I = 1'b0;
        `CHK("outputs after reset", 16'h0000, {OSC_AMP_O, XA_CAP_O, XB_CAP_O})
        for (int i = 0; i < 8; i++) rd(10'(10'h2FF + i), 8'h00);
        // the crystal gets divide-by-2 here; no doubler exists in this bench
        for (int i = 0; i < 6; i++) wr(10'(ADDR_XA_CFG + i), 8'hA5 ^ 8'(i));
        wr(10'h306, 8'hFF);
        step(1);
        `CHK("amp level", 8'hA4, OSC_AMP_O)
        `CHK("cap trims", 8'hA7, {XB_CAP_O, XA_CAP_O})
        for (int i = 0; i < 8; i++) begin
            rd(10'(10'h2FF + i), (i == 0 || i == 7) ? 8'h00 :
                (i == 2 || i == 3) ? 8'hA5 ^ 8'(i - 1) : 8'h25 ^ 8'(i - 1));
        end
        CE_I = 1'b0;
        wr(ADDR_XA_AMP, 8'h11);
        CE_I = 1'b1;
        rd(ADDR_XA_AMP, 8'hA4);
        for (int i = 0; i < 6; i++) wr(10'(ADDR_XA_CFG + i), 8'h00);
        wr(ADDR_IC3, 8'h40);
        step(2);
        `CHK("edge select copy", 4'b1000, EDGE_SEL_O)
        wr(ADDR_IC3, 8'h00);
        step(24);
        for (int ch = 0; ch < 4; ch++) begin
            wr(ch == 0 ? ADDR_XA_CFG : 10'(10'h302 + ch), 8'h20);
            step(3);
            `CHK("monitor feed off", 4'hF ^ (4'h1 << ch), VALID_O)
            wr(ch == 0 ? ADDR_XA_CFG : 10'(10'h302 + ch), 8'h00);
            step(24);
            `CHK("monitor feed on", 4'hF, VALID_O)
        end
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_IC1, 8'(c));
            div_chk(1, PER << c);
        end
        // unused crystal codes fall back to divide by 1
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_XA_CFG, 8'(c));
            div_chk(0, (c == 1) ? 2 * PER : PER);
        end
        wr(ADDR_XA_CFG, 8'h00);
        wr(ADDR_IC1, 8'h00);
        edge_ofs(o0);
        wr(ADDR_IC1, 8'h40);
        edge_ofs(o1);
        `CHK("falling edge offset", 4, (o1 - o0 + 8) % 8)
        wr(ADDR_IC1, 8'h00);
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_IC2, 8'h20);
            step(3);
            wr(ADDR_IC2, 8'(c << 2));
            if (c < 6) begin
                valid_time(2, 1 << (2 * c));
            end else begin
                step(200);
                `CHK("unused window", 1'b0, VALID_O[2])
            end
        end
        // a stopped source must drop valid and restart the full run
        wr(ADDR_IC3, 8'h08);
        step(16 * PER + 24);
        `CHK("valid before stop", 1'b1, VALID_O[3])
        src_run[3] = 1'b0;
        step(MISS + 8);
        `CHK("valid after stop", 1'b0, VALID_O[3])
        src_run[3] = 1'b1;
        valid_time(3, 16);
        end_of_test;
    end
endmodule
`default_nettype wire
